// >>> rtl/twf_consts.svh
// Constants of the tape word framer: instruction fields, function codes,
// status bit positions and timing figures. Definitions only.
`ifndef TWF_CONSTS_SVH
`define TWF_CONSTS_SVH

`define TWF_CLK_PERIOD_NS 4
`define TWF_STATUS_DELAY_US 222
`define TWF_TAPE_SPEED_DIPS 1125
`define TWF_DENS_LO_FPI 200
`define TWF_DENS_HI_FPI 556

`define TWF_IW_MCLR 16
`define TWF_IW_FN_MSB 15
`define TWF_IW_FN_LSB 11
`define TWF_IW_MOD_MSB 10
`define TWF_IW_MOD_LSB 9
`define TWF_IW_OCTAL 8
`define TWF_IW_ODD 7
`define TWF_IW_HIDENS 6

`define TWF_FN_READ 5'h01
`define TWF_FN_WRITE 5'h02
`define TWF_FN_BSPACE 5'h03
`define TWF_FN_SEARCH 5'h04
`define TWF_FN_REWIND 5'h05
`define TWF_FN_SPF_FWD 5'h06
`define TWF_FN_SPF_BWD 5'h07
`define TWF_FN_WTM 5'h08
`define TWF_FN_ADDR 5'h09

`define TWF_F_TMARK 0
`define TWF_F_DIR 1
`define TWF_F_LRC 2
`define TWF_F_LAT 3
`define TWF_F_FCNT 4
`define TWF_F_ITIM 5
`define TWF_F_OTIM 6
`define TWF_F_IMP 7
`define TWF_ST_LOW_BASE 4
`define TWF_ST_IMP_LOW 14
`define TWF_ST_UPPER_OFS 15

`endif

// >>> rtl/twf_pkg.sv
// Types and small decoders shared by the tape word framer modules.
// Assumes twf_consts.svh sits on the include path.
`include "twf_consts.svh"

package twf_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_WRITE = 4'h1,
      ST_WR_GAP = 4'h2,
      ST_WR_LRC = 4'h3,
      ST_READ = 4'h4,
      ST_MOTION = 4'h5,
      ST_DELAY = 4'h6,
      ST_STATUS = 4'h7
   } twf_state_t;

   typedef logic [6:0] twf_frame_t;

   function automatic logic [3:0] twf_frames_per_word(input logic [1:0] modulus);
      twf_frames_per_word = 4'h3 + {2'h0, modulus};
   endfunction

   function automatic logic twf_is_reverse(input logic [4:0] fn);
      twf_is_reverse = (fn == `TWF_FN_BSPACE) || (fn == `TWF_FN_SPF_BWD) || (fn == `TWF_FN_REWIND);
   endfunction
endpackage

// >>> rtl/twf_fmt_if.sv
// Format selection carried from the framer core to its frame coders.
// Assumes one driver (the core) and any number of coders.
`timescale 1ns/1ps

interface twf_fmt_if;
   logic [1:0] modulus;
   logic octal;
   logic odd;
   modport src (output modulus, output octal, output odd);
   modport coder (input modulus, input octal, input odd);
endinterface

// >>> rtl/twf_frame_enc.sv
// Builds one 7-bit tape frame from the leading character bits.
// Assumes chr holds the character left aligned; purely combinational.
`timescale 1ns/1ps

module twf_frame_enc
   import twf_pkg::*;
(
   twf_fmt_if.coder fmt,
   input wire logic [5:0] chr,
   output twf_frame_t frame
);
   logic [5:0] data;

   always_comb
   begin
      data = chr;
      if (fmt.octal)
      begin
         data[2:0] = chr[5:3];
         data[5:3] = (chr[5:3] == 3'h0) ? 3'h7 : chr[5:3];
      end
      frame = {(~^data) ^ ~(fmt.odd | fmt.octal), data};
   end
endmodule

// >>> rtl/twf_frame_chk.sv
// Extracts data bits from a read frame and checks its lateral parity.
// Assumes frames arrive from same-clock transport logic; combinational.
`timescale 1ns/1ps

module twf_frame_chk
   import twf_pkg::*;
(
   twf_fmt_if.coder fmt,
   input twf_frame_t frame,
   output logic [5:0] bits,
   output logic par_err
);
   always_comb
   begin
      bits = fmt.octal ? {3'h0, frame[2:0]} : frame[5:0];
      par_err = (^frame) != (fmt.odd | fmt.octal);
   end
endmodule

// >>> rtl/twf_framer.sv
// Tape word framer core: function intake, word to frame packing on write,
// frame to word assembly on read, parity and status word reporting.
// Assumes channel, function and transport signals are on clk's domain.
`timescale 1ns/1ps
`include "twf_consts.svh"

// Overview of operation
// - Modulus field 00,01,10,11 gives three, four, five, six frames per word.
// - Instruction bit 08 one selects octal recording, zero selects bioctal.
// - Octal frames copy channels 0-2 into 3-5; all zeros become ones.
// - Octal recording always uses odd lateral parity.
// - Octal recording doubles the frames per word.
// - Bit 07 one gives odd frame parity, zero gives even.
// - Bit 06 one selects high density, zero low density.
// - Read words fill low 6*(3+modulus) bits; upper bits are zero.
// - Write splits each word into 6-bit characters, or 3-bit digits in octal, plus a parity bit.
// - After a function ends, wait 222 us, then interrupt with status.
// - Busy device ignores functions except addressing and master clear.
// - Improper condition flag set for bad transport state or request.
// - A new function clears the improper condition flag.
// - Missing first or late output acknowledge sets output timing error.
// - Search key arriving after record read starts flags output timing.
// - Unaccepted input word sets input timing error and stops transfer.
// - Record not filling whole words sets frame count error.
// - Lateral parity mismatch on read sets lateral parity error.
// - Direction flag reports last motion, one meaning backward.
// - Write appends longitudinal parity frame; reads check it.
// - Sensed tape mark sets the tape mark flag.
module twf_framer
   import twf_pkg::*;
#(
   parameter int STATUS_DELAY_CYC = `TWF_STATUS_DELAY_US * 1000 / `TWF_CLK_PERIOD_NS,
   parameter int FRAME_CYC_LO = int'(64'd10000000000 / (64'(`TWF_TAPE_SPEED_DIPS) *
      64'(`TWF_DENS_LO_FPI) * 64'(`TWF_CLK_PERIOD_NS))),
   parameter int FRAME_CYC_HI = int'(64'd10000000000 / (64'(`TWF_TAPE_SPEED_DIPS) *
      64'(`TWF_DENS_HI_FPI) * 64'(`TWF_CLK_PERIOD_NS)))
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic func_valid,
   input wire logic [16:0] func_word,
   input wire logic xport_auto,
   input wire logic xport_selected,
   input wire logic xport_at_eot,
   input wire logic xport_at_load_point,
   input wire logic xport_write_enable,
   input wire logic xport_done,
   output logic [3:0] xport_addr,
   output logic motion_start,
   output logic motion_stop,
   output logic hi_density,
   output twf_frame_t wr_frame,
   output logic wr_frame_valid,
   output logic wr_frame_lrc,
   input wire logic [6:0] rd_frame,
   input wire logic rd_frame_valid,
   input wire logic rd_frame_lrc,
   input wire logic rd_record_end,
   input wire logic rd_tape_mark,
   output logic out_req,
   input wire logic out_ack,
   input wire logic [35:0] out_data,
   output logic in_req,
   input wire logic in_ack,
   output logic [35:0] in_data,
   output logic int_req,
   input wire logic int_ack
);
   generate
      if (STATUS_DELAY_CYC < 1 || FRAME_CYC_LO < 1 || FRAME_CYC_HI < 1)
      begin : g_bad_param
         $error("twf_framer: cycle counts must be at least one");
      end
   endgenerate

   twf_state_t state, next_state;
   logic [4:0] fn, next_fn;
   logic [1:0] modulus, next_modulus;
   logic octal, next_octal, odd, next_odd, next_hi_density;
   logic [3:0] next_xport_addr;
   logic [7:0] flags, next_flags;
   logic [35:0] sr, next_sr, wbuf, next_wbuf, next_in_data;
   logic [3:0] cnt, next_cnt;
   twf_frame_t lrc, next_lrc, next_wr_frame;
   logic have_word, next_have_word, first, next_first, inhibit, next_inhibit;
   logic key_wait, next_key_wait, xfer, next_xfer;
   logic [31:0] ftmr, next_ftmr, dtmr, next_dtmr;
   logic next_out_req, next_in_req, next_int_req;
   logic next_wr_frame_valid, next_wr_frame_lrc, next_motion_start, next_motion_stop;

   twf_fmt_if fmt_bus ();
   logic [3:0] nframes, nbioc;
   logic [35:0] aligned, cur, asm_word, word_mask;
   twf_frame_t enc_frame;
   logic [5:0] rd_bits;
   logic rd_par_err, tick, mclr, addr_fn;
   logic [31:0] period;

   assign fmt_bus.modulus = modulus;
   assign fmt_bus.octal = octal;
   assign fmt_bus.odd = odd;

   twf_frame_enc u_enc (
      .fmt(fmt_bus.coder),
      .chr(cur[35:30]),
      .frame(enc_frame)
   );

   twf_frame_chk u_chk (
      .fmt(fmt_bus.coder),
      .frame(rd_frame),
      .bits(rd_bits),
      .par_err(rd_par_err)
   );

   function automatic logic [35:0] status_word(input logic [7:0] f);
      logic [35:0] w;
      w = '0;
      for (int i = 0; i < 8; i++)
      begin
         if (i == `TWF_F_IMP)
         begin
            w[`TWF_ST_IMP_LOW] = f[i];
            w[`TWF_ST_IMP_LOW + `TWF_ST_UPPER_OFS] = f[i];
         end
         else
         begin
            w[`TWF_ST_LOW_BASE + i] = f[i];
            w[`TWF_ST_LOW_BASE + i + `TWF_ST_UPPER_OFS] = f[i];
         end
      end
      status_word = w;
   endfunction

   always_comb
   begin
      nbioc = twf_frames_per_word(modulus);
      nframes = octal ? {nbioc[2:0], 1'b0} : nbioc;
      aligned = wbuf << (6'd36 - 6'(6 * nbioc));
      cur = (cnt == 4'h0) ? aligned : sr;
      asm_word = octal ? {sr[32:0], rd_bits[2:0]} : {sr[29:0], rd_bits};
      word_mask = 36'hfffffffff >> (6'd36 - 6'(6 * nbioc));
      period = hi_density ? 32'(FRAME_CYC_HI) : 32'(FRAME_CYC_LO);
      tick = (ftmr == 32'h0);
      mclr = func_valid && func_word[`TWF_IW_MCLR];
      addr_fn = func_valid && !mclr && (func_word[`TWF_IW_FN_MSB:`TWF_IW_FN_LSB] == `TWF_FN_ADDR);
   end

   always_comb
   begin
      next_state = state;
      next_fn = fn;
      next_modulus = modulus;
      next_octal = octal;
      next_odd = odd;
      next_hi_density = hi_density;
      next_xport_addr = xport_addr;
      next_flags = flags;
      next_sr = sr;
      next_wbuf = wbuf;
      next_in_data = in_data;
      next_cnt = cnt;
      next_lrc = lrc;
      next_have_word = have_word;
      next_first = first;
      next_inhibit = inhibit;
      next_key_wait = key_wait;
      next_xfer = xfer;
      next_ftmr = tick ? period - 32'h1 : ftmr - 32'h1;
      next_dtmr = 32'h0;
      next_out_req = out_req;
      next_in_req = in_req;
      next_int_req = int_req;
      next_wr_frame = wr_frame;
      next_wr_frame_valid = 1'b0;
      next_wr_frame_lrc = 1'b0;
      next_motion_start = 1'b0;
      next_motion_stop = 1'b0;
      if (addr_fn)
         next_xport_addr = func_word[3:0];
      if (out_req && out_ack)
      begin
         next_wbuf = out_data;
         next_have_word = 1'b1;
         next_out_req = 1'b0;
         next_first = 1'b0;
         next_key_wait = 1'b0;
      end
      if (rd_tape_mark && (state == ST_READ || state == ST_MOTION || state == ST_WRITE))
         next_flags[`TWF_F_TMARK] = 1'b1;
      case (state)
         ST_IDLE:
         begin
            if (func_valid && !mclr && !addr_fn)
            begin
               next_fn = func_word[`TWF_IW_FN_MSB:`TWF_IW_FN_LSB];
               next_modulus = func_word[`TWF_IW_MOD_MSB:`TWF_IW_MOD_LSB];
               next_octal = func_word[`TWF_IW_OCTAL];
               next_odd = func_word[`TWF_IW_ODD];
               next_hi_density = func_word[`TWF_IW_HIDENS];
               next_flags = '0;
               next_flags[`TWF_F_DIR] = twf_is_reverse(next_fn);
               next_cnt = 4'h0;
               next_lrc = '0;
               next_have_word = 1'b0;
               next_inhibit = 1'b0;
               next_ftmr = (func_word[`TWF_IW_HIDENS] ? 32'(FRAME_CYC_HI) : 32'(FRAME_CYC_LO)) - 32'h1;
               if (!xport_auto || !xport_selected || (!next_flags[`TWF_F_DIR] && xport_at_eot) ||
                   (next_flags[`TWF_F_DIR] && next_fn != `TWF_FN_REWIND && xport_at_load_point) ||
                   ((next_fn == `TWF_FN_WRITE || next_fn == `TWF_FN_WTM) && !xport_write_enable))
               begin
                  next_flags[`TWF_F_IMP] = 1'b1;
                  next_state = ST_DELAY;
               end
               else
               begin
                  next_motion_start = 1'b1;
                  if (next_fn == `TWF_FN_WRITE)
                  begin
                     next_state = ST_WRITE;
                     next_out_req = 1'b1;
                     next_first = 1'b1;
                  end
                  else if (next_fn == `TWF_FN_READ || next_fn == `TWF_FN_SEARCH || next_fn == `TWF_FN_BSPACE)
                  begin
                     next_state = ST_READ;
                     next_xfer = (next_fn != `TWF_FN_BSPACE);
                     next_key_wait = (next_fn == `TWF_FN_SEARCH);
                     next_out_req = (next_fn == `TWF_FN_SEARCH);
                  end
                  else
                     next_state = ST_MOTION;
               end
            end
         end
         ST_WRITE:
         begin
            if (tick)
            begin
               if (cnt != 4'h0 || have_word)
               begin
                  next_wr_frame = enc_frame;
                  next_wr_frame_valid = 1'b1;
                  next_lrc = lrc ^ enc_frame;
                  next_sr = octal ? (cur << 3) : (cur << 6);
                  next_cnt = ((cnt == 4'h0) ? nframes : cnt) - 4'h1;
                  if (cnt == 4'h0)
                  begin
                     next_have_word = 1'b0;
                     next_out_req = 1'b1;
                  end
               end
               else if (first)
               begin
                  next_flags[`TWF_F_OTIM] = 1'b1;
                  next_out_req = 1'b0;
                  next_state = ST_DELAY;
               end
               else
                  next_state = ST_WR_GAP;
            end
         end
         ST_WR_GAP:
         begin
            if (have_word)
            begin
               next_flags[`TWF_F_OTIM] = 1'b1;
               next_state = ST_WRITE;
            end
            else if (tick)
            begin
               next_out_req = 1'b0;
               next_state = ST_WR_LRC;
            end
         end
         ST_WR_LRC:
         begin
            if (tick)
            begin
               next_wr_frame = lrc;
               next_wr_frame_valid = !mclr;
               next_wr_frame_lrc = !mclr;
               next_state = ST_DELAY;
            end
         end
         ST_READ:
         begin
            if (in_req && in_ack)
               next_in_req = 1'b0;
            if (rd_frame_valid && rd_frame_lrc)
            begin
               if ((lrc ^ rd_frame) != 7'h0)
                  next_flags[`TWF_F_LRC] = 1'b1;
            end
            else if (rd_frame_valid)
            begin
               next_lrc = lrc ^ rd_frame;
               if (key_wait && !(out_req && out_ack))
               begin
                  next_flags[`TWF_F_OTIM] = 1'b1;
                  next_key_wait = 1'b0;
                  next_out_req = 1'b0;
               end
               if (rd_par_err)
               begin
                  next_flags[`TWF_F_LAT] = 1'b1;
                  next_inhibit = 1'b1;
               end
               next_sr = asm_word;
               if (cnt + 4'h1 == nframes)
               begin
                  next_cnt = 4'h0;
                  if (xfer && !next_inhibit)
                  begin
                     if (in_req && !in_ack)
                     begin
                        next_flags[`TWF_F_ITIM] = 1'b1;
                        next_inhibit = 1'b1;
                        next_in_req = 1'b0;
                     end
                     else
                     begin
                        next_in_data = asm_word & word_mask;
                        next_in_req = 1'b1;
                     end
                  end
               end
               else
                  next_cnt = cnt + 4'h1;
            end
            if (rd_record_end)
            begin
               if (next_cnt != 4'h0)
                  next_flags[`TWF_F_FCNT] = 1'b1;
               next_in_req = 1'b0;
               next_out_req = 1'b0;
               next_state = ST_DELAY;
            end
         end
         ST_MOTION:
         begin
            if (xport_done)
               next_state = ST_DELAY;
         end
         ST_DELAY:
         begin
            next_dtmr = dtmr + 32'h1;
            if (dtmr == 32'(STATUS_DELAY_CYC - 1))
            begin
               next_in_data = status_word(flags);
               next_int_req = 1'b1;
               next_state = ST_STATUS;
            end
         end
         ST_STATUS:
         begin
            if (int_ack)
            begin
               next_int_req = 1'b0;
               next_state = ST_IDLE;
            end
         end
         default:
            next_state = ST_IDLE;
      endcase
      if (mclr)
      begin
         next_state = ST_IDLE;
         next_flags = '0;
         next_out_req = 1'b0;
         next_in_req = 1'b0;
         next_int_req = 1'b0;
         next_motion_stop = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state <= ST_IDLE;
         fn <= 5'h00;
         modulus <= 2'h0;
         octal <= 1'b0;
         odd <= 1'b0;
         hi_density <= 1'b0;
         xport_addr <= 4'h0;
         flags <= 8'h00;
         sr <= 36'h0;
         wbuf <= 36'h0;
         in_data <= 36'h0;
         cnt <= 4'h0;
         lrc <= 7'h00;
         have_word <= 1'b0;
         first <= 1'b0;
         inhibit <= 1'b0;
         key_wait <= 1'b0;
         xfer <= 1'b0;
         ftmr <= 32'h0;
         dtmr <= 32'h0;
         out_req <= 1'b0;
         in_req <= 1'b0;
         int_req <= 1'b0;
         wr_frame <= 7'h00;
         wr_frame_valid <= 1'b0;
         wr_frame_lrc <= 1'b0;
         motion_start <= 1'b0;
         motion_stop <= 1'b0;
      end
      else
      begin
         state <= next_state;
         fn <= next_fn;
         modulus <= next_modulus;
         octal <= next_octal;
         odd <= next_odd;
         hi_density <= next_hi_density;
         xport_addr <= next_xport_addr;
         flags <= next_flags;
         sr <= next_sr;
         wbuf <= next_wbuf;
         in_data <= next_in_data;
         cnt <= next_cnt;
         lrc <= next_lrc;
         have_word <= next_have_word;
         first <= next_first;
         inhibit <= next_inhibit;
         key_wait <= next_key_wait;
         xfer <= next_xfer;
         ftmr <= next_ftmr;
         dtmr <= next_dtmr;
         out_req <= next_out_req;
         in_req <= next_in_req;
         int_req <= next_int_req;
         wr_frame <= next_wr_frame;
         wr_frame_valid <= next_wr_frame_valid;
         wr_frame_lrc <= next_wr_frame_lrc;
         motion_start <= next_motion_start;
         motion_stop <= next_motion_stop;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence wr_starved_s;
      state == ST_WRITE && tick && cnt == 4'h0 && !have_word && first && !mclr;
   endsequence

   sequence status_wait_s;
      int_req && !int_ack && !mclr;
   endsequence

   status_hold_a: assert property (status_wait_s |=> int_req && $stable(in_data))
      else $error("status word changed before acknowledge");
   status_delay_a: assert property ($rose(int_req) |-> $past(state) == ST_DELAY &&
      $past(dtmr) == 32'(STATUS_DELAY_CYC - 1))
      else $error("status interrupt raised without full delay");
   busy_ignore_a: assert property (state == ST_STATUS && func_valid && !mclr && !int_ack
      |=> state == ST_STATUS)
      else $error("function accepted while status pending");
   improper_we_a: assert property (state == ST_IDLE && func_valid && !mclr &&
      func_word[15:11] == `TWF_FN_WRITE && !xport_write_enable
      |=> flags[`TWF_F_IMP] && state == ST_DELAY)
      else $error("write without enable not flagged improper");
   octal_frame_a: assert property (wr_frame_valid && !wr_frame_lrc && octal |-> (^wr_frame) &&
      wr_frame[5:3] == ((wr_frame[2:0] == 3'h0) ? 3'h7 : wr_frame[2:0]))
      else $error("octal frame coding wrong");
   frame_parity_a: assert property (wr_frame_valid && !wr_frame_lrc && !octal |-> (^wr_frame) == odd)
      else $error("frame parity does not follow selection");
   first_ack_a: assert property (wr_starved_s |=> flags[`TWF_F_OTIM] && state == ST_DELAY)
      else $error("missing first acknowledge not flagged");
   read_width_a: assert property ($rose(in_req) && state == ST_READ
      |-> (in_data & ~word_mask) == 36'h0)
      else $error("read word has bits above modulus width");
   lrc_frame_a: assert property (wr_frame_valid && wr_frame_lrc |-> state == ST_DELAY && wr_frame == lrc)
      else $error("longitudinal frame differs from accumulated parity");
   frame_count_a: assert property (state == ST_READ && rd_record_end && !rd_frame_valid && cnt != 4'h0
      && !mclr |=> flags[`TWF_F_FCNT])
      else $error("partial word at record end not flagged");
endmodule

// >>> tb/twf_chan_model.sv
// Channel side model: answers output, input and status requests.
// Assumes the framer's clock; drives one step after each rising edge.
`timescale 1ns/1ps

module twf_chan_model
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic out_req,
   input wire logic in_req,
   input wire logic int_req,
   input wire logic out_en,
   input wire logic in_stall,
   input wire logic [35:0] wr_word,
   output logic out_ack,
   output logic [35:0] out_data,
   output logic in_ack,
   output logic int_ack
);
   logic sent = 1'h0;
   initial
   begin
      {out_ack, in_ack, int_ack} = 3'h0;
      out_data = 36'h0;
   end
   always @(posedge clk)
   begin
      #1;
      out_ack = resetn && out_req && out_en && !sent; // One word, sent at once
      sent = resetn && out_en && (sent || out_ack);
      out_data = out_ack ? wr_word : ~wr_word;
      in_ack = resetn && in_req && !in_stall && !in_ack;
      int_ack = resetn && int_req && !int_ack; // Status answered before any new function
   end
endmodule

// >>> tb/tb_top.sv
// Testbench: a row table of read, write, backspace and search functions, then transport, addressing, master clear and reset cases.
// Assumes the rtl package, interface and framer modules are compiled first.
`timescale 1ns/1ps

module tb_top
   import twf_pkg::*;
;
   typedef struct {logic [16:0] fw; int nfr; logic bad, stl, we, oe, tm; int nw; logic [35:0] st;} twf_row_t;
   localparam logic [35:0] W = 36'hf8e0c0a07;
   logic clk = 0, resetn = 0, func_valid = 0, xport_write_enable = 1, rd_frame_valid = 0, rd_frame_lrc = 0;
   logic xport_auto = 1, xport_selected = 1, xport_at_eot = 0, xport_at_load_point = 0, xport_done = 0;
   logic rd_record_end = 0, rd_tape_mark = 0, out_en = 0, in_stall = 0, out_ack, in_ack, int_ack;
   logic out_req, in_req, int_req, motion_start, motion_stop, hi_density, wr_frame_valid, wr_frame_lrc;
   logic [16:0] func_word = 17'h0;
   logic [6:0] rd_frame = 7'h0;
   logic [35:0] out_data, in_data;
   logic [3:0] xport_addr;
   twf_frame_t wr_frame, f, lrc;
   twf_frame_t frames[$];
   logic [35:0] rdw[$];
   int error_cnt = 0, compares = 0, cnt;
   twf_row_t rows[16] = '{'{17'h01080, 4, 0, 0, 1, 1, 0, 0, 36'h0}, '{17'h01240, 5, 0, 0, 1, 1, 0, 0, 36'h0},
      '{17'h01500, 11, 0, 0, 1, 1, 0, 0, 36'h0}, '{17'h016c0, 7, 0, 0, 1, 1, 0, 0, 36'h0},
      '{17'h01080, 0, 0, 0, 0, 1, 0, 0, 36'h020004000}, '{17'h01080, 0, 0, 0, 1, 0, 0, 0, 36'h002000400},
      '{17'h00800, 3, 0, 0, 1, 0, 0, 1, 36'h0}, '{17'h00a00, 4, 0, 0, 1, 0, 0, 1, 36'h0},
      '{17'h00e80, 6, 0, 0, 1, 0, 0, 1, 36'h0}, '{17'h00a00, 6, 0, 0, 1, 0, 0, 1, 36'h000800100},
      '{17'h00a00, 4, 1, 0, 1, 0, 0, 0, 36'h000400080}, '{17'h00a00, 8, 0, 1, 1, 0, 0, 0, 36'h001000200},
      '{17'h00a00, 4, 0, 0, 1, 0, 1, 1, 36'h000080010}, '{17'h01a00, 4, 0, 0, 1, 0, 0, 0, 36'h000100020},
      '{17'h02200, 4, 0, 0, 1, 1, 0, 1, 36'h0}, '{17'h02200, 4, 0, 0, 1, 0, 0, 1, 36'h002000400}};

   twf_framer #(.STATUS_DELAY_CYC(8), .FRAME_CYC_LO(4), .FRAME_CYC_HI(3)) dut (.clk, .resetn, .func_valid,
      .func_word, .xport_auto, .xport_selected, .xport_at_eot, .xport_at_load_point,
      .xport_write_enable, .xport_done, .xport_addr, .motion_start, .motion_stop, .hi_density,
      .wr_frame, .wr_frame_valid, .wr_frame_lrc, .rd_frame, .rd_frame_valid, .rd_frame_lrc, .rd_record_end,
      .rd_tape_mark, .out_req, .out_ack, .out_data, .in_req, .in_ack, .in_data, .int_req, .int_ack);
   twf_chan_model chan (.clk, .resetn, .out_req, .in_req, .int_req, .out_en, .in_stall, .wr_word(W),
      .out_ack, .out_data, .in_ack, .int_ack);

   task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
      compares++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run();
      $display("mismatches %0d, compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      @(posedge clk) #1 s = 1;
      @(posedge clk) #1 s = 0;
   endtask
   task automatic func(input logic [16:0] fw);
      func_word = fw;
      pulse(func_valid);
   endtask
   task automatic send(input twf_frame_t fr, input logic l);
      rd_frame = fr;
      rd_frame_lrc = l;
      pulse(rd_frame_valid);
      rd_frame = ~fr;
      rd_frame_lrc = 0;
   endtask
   task automatic wstat(input logic [35:0] e);
      cnt = 0;
      while (int_req !== 1'b1 && cnt < 3000)
      begin
         @(negedge clk);
         cnt++;
      end
      chk("int_req", 36'h1, 36'(int_req));
      chk("delay", 36'h1, 36'(cnt >= 6));
      chk("status", e, in_data);
      out_en = 0;
      in_stall = 0;
      repeat (3) @(posedge clk);
   endtask
   // Expected frame i of word W for the given format
   function automatic twf_frame_t ef(input logic [16:0] fw, input int i);
      logic [5:0] c;
      int n;
      n = (fw[10:9] + 3) * (fw[8] ? 2 : 1);
      c = 6'(W >> ((fw[8] ? 3 : 6) * (n - 1 - i % n)));
      if (fw[8])
         c[5:3] = (c[2:0] == 3'h0) ? 3'h7 : c[2:0];
      return {(fw[7] | fw[8]) ? ~^c : ^c, c};
   endfunction

   always @(negedge clk)
   begin
      if (wr_frame_valid)
         frames.push_back(wr_frame ^ {wr_frame_lrc, 6'h0}); // Marked lrc frame flips bit 6
      if (in_req && in_ack)
         rdw.push_back(in_data);
   end
   initial
   begin
      forever #2 clk = ~clk;
   end
   initial
   begin
      #200000;
      error_cnt++;
      complete_run();
   end
   initial
   begin
      repeat (6) @(posedge clk);
      #1 resetn = 1;
      chk("reset", 36'h0, {int_req, in_req, out_req, wr_frame_valid, motion_start});
      foreach (rows[k])
      begin
         xport_write_enable = rows[k].we;
         out_en = rows[k].oe;
         in_stall = rows[k].stl;
         frames = {};
         func(rows[k].fw);
         rdw = {};
         if (rows[k].we)
            chk("hi_density", 36'(rows[k].fw[6]), 36'(hi_density));
         if (rows[k].fw[15:11] != 5'h02)
         begin
            func(17'h01080);
            lrc = 7'h0;
            for (int i = 0; i < rows[k].nfr; i++)
            begin
               f = ef(rows[k].fw, i) ^ ((rows[k].bad && i == 0) ? 7'h40 : 7'h00);
               lrc ^= f;
               send(f, 0);
            end
            if (rows[k].tm)
               pulse(rd_tape_mark);
            send(lrc, 1);
            pulse(rd_record_end);
         end
         wstat(rows[k].st);
         if (rows[k].fw[15:11] == 5'h02)
         begin
            chk("frames", 36'(rows[k].nfr), 36'(frames.size()));
            lrc = 7'h0;
            for (int i = 0; i < rows[k].nfr - 1; i++)
            begin
               chk("frame", 36'(ef(rows[k].fw, i)), 36'(frames[i]));
               lrc ^= frames[i];
            end
            if (rows[k].nfr > 0)
               chk("lrc", 36'(lrc ^ 7'h40), 36'(frames[rows[k].nfr - 1]));
         end
         else if (!rows[k].stl)
         begin
            chk("words", 36'(rows[k].nw), 36'(rdw.size()));
            foreach (rdw[j])
               chk("word", W & ((36'h1 << (6 * (rows[k].fw[10:9] + 3))) - 36'h1), rdw[j]);
         end
      end
      xport_at_load_point = 1;
      func(17'h01a00);
      wstat(36'h020104020);
      func(17'h02800);
      chk("motion_start", 36'h1, 36'(motion_start));
      pulse(xport_done);
      wstat(36'h000100020);
      xport_at_load_point = 0;
      for (int j = 0; j < 3; j++)
      begin
         {xport_auto, xport_selected, xport_at_eot} = 3'b110 ^ 3'(3'b100 >> j);
         func(17'h00800);
         wstat(36'h020004000);
      end
      {xport_auto, xport_selected, xport_at_eot} = 3'b110;
      func(17'h04805);
      chk("xport_addr", 36'h5, 36'(xport_addr));
      func(17'h01080);
      func(17'h10000);
      chk("master_clear", 36'h4, {motion_stop, out_req, int_req});
      repeat (12) @(posedge clk);
      chk("no_status", 36'h0, 36'(int_req));
      func(17'h01240);
      @(posedge clk) #1 resetn = 0;
      #1 chk("reset", 36'h0, {int_req, in_req, out_req, wr_frame_valid, motion_start, hi_density});
      complete_run();
   end
endmodule
